// ==== include/mbp_pkg.sv ====
// Package of constants for the multiplexed host port block
package mbp_pkg;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int          MBP_DATA_W   = 8;      // Shared bus width
  localparam int          MBP_REG_N    = 256;    // Addressable bytes
  localparam int          MBP_FLAG_W   = 8;      // Status flag width
  localparam logic [7:0]  MBP_RST_BYTE = 8'h00;  // Register reset value
  localparam logic [7:0]  MBP_RST_ADDR = 8'h00;  // Address latch reset
  localparam logic [2:0]  MBP_SYNC_RST = 3'h7;   // Idle-high pin sync

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int MBP_CLK_NS    = 8;   // Clock period in ns
  // Least delay from read strobe fall to data drive, ns
  localparam int MBP_DDR_MIN_NS = 20;
  // Cycles, rounded up, at least one
  localparam int MBP_DDR_CYC =
    ((MBP_DDR_MIN_NS + MBP_CLK_NS - 1) / MBP_CLK_NS) < 1 ? 1 :
    ((MBP_DDR_MIN_NS + MBP_CLK_NS - 1) / MBP_CLK_NS);

  // ****************************************************************
  // Bus cycle states (Gray along idle -> wait -> drive)
  // ****************************************************************
  typedef enum logic [1:0] {
    MBP_IDLE  = 2'b00,
    MBP_WAIT  = 2'b01,
    MBP_DRIVE = 2'b11
  } mbp_rd_state_t;

endpackage : mbp_pkg

// ==== design/mbp_sync.sv ====
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none

module mbp_sync
  import mbp_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Pin and filtered level
  input  wire logic pin,
  output logic      level
);

  // ****************************************************************
  // Sync chain
  // ****************************************************************
  logic [2:0] stage;       // Flop chain, stage[0] is the first flop
  logic [2:0] next_stage;  // Next chain value
  logic       next_level;  // Next filtered level

  // Shift; output follows only once stages two and three agree
  always_comb
  begin
    next_stage = {stage[1:0], pin};
    next_level = level;
    if (stage[1] == stage[2])
    begin
      next_level = stage[2];
    end
  end

  // Register the chain; idle high suits active-low pins
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stage <= MBP_SYNC_RST;
      level <= 1'b1;
    end
    else
    begin
      stage <= next_stage;
      level <= next_level;
    end
  end

endmodule // mbp_sync
`default_nettype wire

// ==== design/mbp_host_port.sv ====
// Multiplexed address/data host port with interrupt and power-on pins
`timescale 1ns/1ps
`default_nettype none

module mbp_host_port
  import mbp_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // Shared address/data bus pins
  input  wire logic [mbp_pkg::MBP_DATA_W-1:0] shared_addr_data_bus_in,
  output logic      [mbp_pkg::MBP_DATA_W-1:0] shared_addr_data_bus_out,
  output logic                                shared_addr_data_bus_oe,
  // Bus strobes
  input  wire logic                          addr_latch,
  input  wire logic                          chip_sel_n,
  input  wire logic                          rd_n,
  input  wire logic                          wr_n,
  // Interrupt request, open drain
  output logic                               irq_n_out,
  output logic                               irq_n_oe,
  // Kickstart and power-on control
  input  wire logic                          kickstart_in_n,
  output logic                               power_on_ctrl_n_out,
  output logic                               power_on_ctrl_n_oe,
  // Supply status and control bits
  input  wire logic                          main_supply_ok,
  input  wire logic                          aux_supply_ok,
  input  wire logic                          aux_battery_enable,
  input  wire logic                          sw_power_on,
  input  wire logic                          wake_event,
  input  wire logic                          ks_flag_clr,
  // Flags, enables and register file access for the core
  input  wire logic [mbp_pkg::MBP_FLAG_W-1:0] status_flags,
  input  wire logic [mbp_pkg::MBP_FLAG_W-1:0] irq_enables,
  output logic                               ks_flag,
  output logic [mbp_pkg::MBP_DATA_W-1:0]     last_addr,
  output logic                               wr_pulse,
  output logic [mbp_pkg::MBP_DATA_W-1:0]     wr_data
);
  import mbp_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic ale_n_s;  // Inverted address strobe: idle high like the others
  logic cs_s;   // Filtered chip select, active low
  logic rd_s;   // Filtered read strobe, active low
  logic wr_s;   // Filtered write strobe, active low
  logic ks_s;   // Filtered kickstart, active low

  mbp_sync u_ale (.clk_sys(clk_sys), .rst(rst), .pin(~addr_latch),
                  .level(ale_n_s));
  mbp_sync u_cs  (.clk_sys(clk_sys), .rst(rst), .pin(chip_sel_n),
                  .level(cs_s));
  mbp_sync u_rd  (.clk_sys(clk_sys), .rst(rst), .pin(rd_n),
                  .level(rd_s));
  mbp_sync u_wr  (.clk_sys(clk_sys), .rst(rst), .pin(wr_n),
                  .level(wr_s));
  mbp_sync u_ks  (.clk_sys(clk_sys), .rst(rst), .pin(kickstart_in_n),
                  .level(ks_s));

  // Bus data is sampled through a delayed copy so it is stable at edges
  logic [MBP_DATA_W-1:0] bus_d1;  // First sample of the bus
  logic [MBP_DATA_W-1:0] bus_d2;  // Second sample of the bus
  logic [MBP_DATA_W-1:0] bus_d3;  // Matches strobe filter latency

  // ****************************************************************
  // Edge detection and register storage
  // ****************************************************************
  logic ale_n_q;  // Previous inverted address strobe
  logic wr_q;   // Previous filtered write strobe
  logic ks_q;   // Previous filtered kickstart
  logic ale_fall;
  logic wr_rise;
  logic ks_fall;

  logic [MBP_DATA_W-1:0] regs [MBP_REG_N];  // Byte-wide register file
  logic [MBP_DATA_W-1:0] next_last_addr;
  logic                  next_wr_pulse;
  logic [MBP_DATA_W-1:0] next_wr_data;
  logic                  next_ks_flag;

  assign ale_fall = ~ale_n_q & ale_n_s;
  assign wr_rise  = ~wr_q & wr_s;
  assign ks_fall  = ks_q & ~ks_s;

  // Access is only allowed when selected and the main supply is good
  function automatic logic access_ok(input logic cs_n, input logic vcc);
    return ~cs_n & vcc;
  endfunction

  // Compute address latch, write strobe and kickstart flag
  always_comb
  begin
    next_last_addr = last_addr;
    next_wr_pulse  = 1'b0;
    next_wr_data   = wr_data;
    next_ks_flag   = ks_flag;
    // Latched even when deselected or supply is low
    if (ale_fall)
    begin
      next_last_addr = bus_d3;
    end
    // Chip select checked at write end; host keeps it low meanwhile
    if (wr_rise && access_ok(cs_s, main_supply_ok))
    begin
      next_wr_pulse = 1'b1;
      next_wr_data  = bus_d3;
    end
    // Clear first so an event in the same cycle wins
    if (ks_flag_clr)
    begin
      next_ks_flag = 1'b0;
    end
    if (ks_fall && main_supply_ok)
    begin
      next_ks_flag = 1'b1;
    end
  end

  // Register edge history, address and write data
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bus_d1    <= MBP_RST_BYTE;
      bus_d2    <= MBP_RST_BYTE;
      bus_d3    <= MBP_RST_BYTE;
      ale_n_q   <= 1'b1;
      wr_q      <= 1'b1;
      ks_q      <= 1'b1;
      last_addr <= MBP_RST_ADDR;
      wr_pulse  <= 1'b0;
      wr_data   <= MBP_RST_BYTE;
      ks_flag   <= 1'b0;
    end
    else
    begin
      bus_d1    <= shared_addr_data_bus_in;
      bus_d2    <= bus_d1;
      bus_d3    <= bus_d2;
      ale_n_q   <= ale_n_s;
      wr_q      <= wr_s;
      ks_q      <= ks_s;
      last_addr <= next_last_addr;
      wr_pulse  <= next_wr_pulse;
      wr_data   <= next_wr_data;
      ks_flag   <= next_ks_flag;
    end
  end

  // Register file has no reset; contents belong to software
  always_ff @(posedge clk_sys)
  begin
    if (wr_pulse)
    begin
      regs[last_addr] <= wr_data;
    end
  end

  // ****************************************************************
  // Read cycle machine
  // ****************************************************************
  mbp_rd_state_t          rd_state;
  mbp_rd_state_t          next_rd_state;
  logic [1:0]             rd_cnt;       // Delay before driving
  logic [1:0]             next_rd_cnt;
  logic [MBP_DATA_W-1:0]  next_bus_out;
  logic                   next_bus_oe;

  // Drive only after the least output delay; drop at strobe rise
  always_comb
  begin
    next_rd_state = rd_state;
    next_rd_cnt   = rd_cnt;
    next_bus_out  = shared_addr_data_bus_out;
    next_bus_oe   = 1'b0;
    case (rd_state)
      MBP_IDLE:
      begin
        next_rd_cnt = 2'h0;
        if (!rd_s && access_ok(cs_s, main_supply_ok))
        begin
          next_rd_state = MBP_WAIT;
        end
      end
      MBP_WAIT:
      begin
        if (rd_s)
        begin
          next_rd_state = MBP_IDLE;
        end
        else if (rd_cnt >= 2'(MBP_DDR_CYC - 1))
        begin
          next_rd_state = MBP_DRIVE;
          next_bus_out  = regs[last_addr];
          next_bus_oe   = 1'b1;
        end
        else
        begin
          next_rd_cnt = rd_cnt + 2'h1;
        end
      end
      MBP_DRIVE:
      begin
        if (rd_s)
        begin
          next_rd_state = MBP_IDLE;
        end
        else
        begin
          next_bus_oe = 1'b1;
        end
      end
      default:
      begin
        next_rd_state = MBP_IDLE;
      end
    endcase
  end

  // Register read state and bus drive
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rd_state                 <= MBP_IDLE;
      rd_cnt                   <= 2'h0;
      shared_addr_data_bus_out <= MBP_RST_BYTE;
      shared_addr_data_bus_oe  <= 1'b0;
    end
    else
    begin
      rd_state                 <= next_rd_state;
      rd_cnt                   <= next_rd_cnt;
      shared_addr_data_bus_out <= next_bus_out;
      shared_addr_data_bus_oe  <= next_bus_oe;
    end
  end

  // ****************************************************************
  // Interrupt and power-on pins
  // ****************************************************************
  logic irq_active;      // Any enabled flag or the kickstart flag set
  logic next_irq_oe;
  logic pwr_latch;       // Power-on request held without supply
  logic next_pwr_latch;
  logic next_pwr_oe;

  // Kickstart flag participates as an extra interrupt source
  assign irq_active = |(status_flags & irq_enables) | ks_flag;

  // Open-drain outputs only ever drive low
  assign irq_n_out           = 1'b0;
  assign power_on_ctrl_n_out = 1'b0;

  // Without supply, wake or kickstart latch power on; with it, software
  always_comb
  begin
    next_irq_oe    = irq_active;
    next_pwr_latch = pwr_latch;
    if (!main_supply_ok)
    begin
      if (wake_event ||
          (ks_fall && aux_battery_enable && aux_supply_ok))
      begin
        next_pwr_latch = 1'b1;
      end
      next_pwr_oe = next_pwr_latch;
    end
    else
    begin
      next_pwr_latch = sw_power_on;
      next_pwr_oe    = sw_power_on;
    end
  end

  // Register open-drain enables
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irq_n_oe           <= 1'b0;
      pwr_latch          <= 1'b0;
      power_on_ctrl_n_oe <= 1'b0;
    end
    else
    begin
      irq_n_oe           <= next_irq_oe;
      pwr_latch          <= next_pwr_latch;
      power_on_ctrl_n_oe <= next_pwr_oe;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_read_low;
    !rd_s && access_ok(cs_s, main_supply_ok);
  endsequence

  a_irq_follows_flags: assert property (@(posedge clk_sys) disable iff (rst)
    irq_active |=> irq_n_oe)
    else $error("irq not driven with enabled flag");
  a_irq_released: assert property (@(posedge clk_sys) disable iff (rst)
    !irq_active |=> !irq_n_oe)
    else $error("irq driven without condition");
  a_bus_release: assert property (@(posedge clk_sys) disable iff (rst)
    rd_s |=> !shared_addr_data_bus_oe)
    else $error("bus not released after read end");
  a_read_drive: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_state == MBP_IDLE) ##0 s_read_low ##1 (!rd_s)[*4] |->
      shared_addr_data_bus_oe)
    else $error("read data not driven");
  a_read_delay: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(shared_addr_data_bus_oe) |-> $past(rd_state) == MBP_WAIT)
    else $error("bus driven too early");
  a_addr_latch: assert property (@(posedge clk_sys) disable iff (rst)
    ale_fall |=> last_addr == $past(bus_d3))
    else $error("address not latched");
  a_write_gate: assert property (@(posedge clk_sys) disable iff (rst)
    wr_pulse |-> !$past(cs_s) && $past(main_supply_ok))
    else $error("write without access");
  a_no_read_nosupply: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_state == MBP_IDLE && !main_supply_ok) |=> rd_state == MBP_IDLE)
    else $error("read accepted during supply fail");
  a_power_sw: assert property (@(posedge clk_sys) disable iff (rst)
    main_supply_ok |=> power_on_ctrl_n_oe == $past(sw_power_on))
    else $error("power pin not under software");
  a_power_wake: assert property (@(posedge clk_sys) disable iff (rst)
    (!main_supply_ok && wake_event) |=> power_on_ctrl_n_oe)
    else $error("wake did not power on");
  a_ks_enable: assert property (@(posedge clk_sys) disable iff (rst)
    (!main_supply_ok && !wake_event && !pwr_latch && !aux_battery_enable)
      |=> !power_on_ctrl_n_oe)
    else $error("kickstart ignored enable bit");
  a_ks_irq: assert property (@(posedge clk_sys) disable iff (rst)
    (ks_fall && main_supply_ok) |=> ks_flag)
    else $error("kickstart flag not set");

endmodule // mbp_host_port
`default_nettype wire

// ==== sim/mbp_host_model.sv ====
// Host bus master model for the multiplexed address/data port
`timescale 1ns/1ps
`default_nettype none
module mbp_host_model
(
  // Clock
  input  wire logic       clk_sys,
  // Wire level and device drive
  input  wire logic [7:0] bus_level,
  input  wire logic       dev_oe,
  // Host pins
  output var  logic [7:0] host_val,
  output var  logic       host_drv,
  output var  logic       addr_latch,
  output var  logic       chip_sel_n,
  output var  logic       rd_n,
  output var  logic       wr_n
);
  // Idle: strobes inactive, bus released
  initial
  begin
    host_val = 8'h00;
    host_drv = 1'b0;
    addr_latch = 1'b0;
    chip_sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
  end
  // One bus cycle; each level held 4+ cycles to pass the pin filter
  task automatic bus_cycle(input logic [7:0] a, input logic [7:0] d,
                           input bit wr, input bit sel,
                           output logic [7:0] q, output bit to);
    int i;
    to = 1'b0;
    q = 8'h00;
    @(posedge clk_sys);
    host_val <= a;
    host_drv <= 1'b1;
    addr_latch <= 1'b1;
    repeat (6) @(posedge clk_sys);
    addr_latch <= 1'b0;
    repeat (6) @(posedge clk_sys);
    // Select ahead of the strobe, kept until after it
    chip_sel_n <= ~sel;
    host_val <= d;
    host_drv <= wr;
    repeat (4) @(posedge clk_sys);
    if (wr)
    begin
      wr_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      wr_n <= 1'b1;
    end
    else
    begin
      rd_n <= 1'b0;
      for (i = 0; i < 40 && dev_oe !== 1'b1; i++)
        @(posedge clk_sys);
      to = (i == 40);
      q = bus_level;
      rd_n <= 1'b1;
    end
    // Data hold, then release select and bus
    repeat (6) @(posedge clk_sys);
    chip_sel_n <= 1'b1;
    host_drv <= 1'b0;
    for (i = 0; i < 20 && dev_oe !== 1'b0; i++)
      @(posedge clk_sys);
    if (i == 20)
      to = 1'b1;
  endtask
endmodule // mbp_host_model
`default_nettype wire

// ==== sim/muxed_bus_irq_power_pins_tb_top.sv ====
// Self-checking bench for the multiplexed host port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module muxed_bus_irq_power_pins_tb_top;
  // Clock, reset and pins
  logic clk_sys, rst, hdrv, ale, cs_n, rd_n, wr_n, dev_oe;
  logic [7:0] bus_wire, last_bus, dev_out, hval, flags, ens;
  logic irq_out, irq_oe, ks_n, pwr_out, pwr_oe, main_ok, aux_ok, abe;
  logic sw_on, wake, ks_clr, ks_flag, wr_pulse;
  logic [7:0] last_addr, wr_data, wr_seen;
  logic [7:0] model [int]; // Expected register contents
  int n_fail, total_checks, n_wr;
  // Undriven bus flips every cycle so stale data never matches
  assign bus_wire = dev_oe ? dev_out : (hdrv ? hval : ~last_bus);
  always @(posedge clk_sys)
    last_bus <= bus_wire;
  // Count write pulses seen by the register file
  always @(posedge clk_sys)
    if (wr_pulse === 1'b1)
    begin
      n_wr++;
      wr_seen = wr_data;
    end
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  mbp_host_model mbp_host_model_inst (.clk_sys(clk_sys), .bus_level(bus_wire),
    .dev_oe(dev_oe), .host_val(hval), .host_drv(hdrv), .addr_latch(ale),
    .chip_sel_n(cs_n), .rd_n(rd_n), .wr_n(wr_n));
  mbp_host_port mbp_host_port_inst (.clk_sys(clk_sys), .rst(rst),
    .shared_addr_data_bus_in(bus_wire), .shared_addr_data_bus_out(dev_out),
    .shared_addr_data_bus_oe(dev_oe), .addr_latch(ale), .chip_sel_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .irq_n_out(irq_out), .irq_n_oe(irq_oe),
    .kickstart_in_n(ks_n), .power_on_ctrl_n_out(pwr_out),
    .power_on_ctrl_n_oe(pwr_oe), .main_supply_ok(main_ok),
    .aux_supply_ok(aux_ok), .aux_battery_enable(abe), .sw_power_on(sw_on),
    .wake_event(wake), .ks_flag_clr(ks_clr), .status_flags(flags),
    .irq_enables(ens), .ks_flag(ks_flag), .last_addr(last_addr),
    .wr_pulse(wr_pulse), .wr_data(wr_data));
  // Verdict and end of run
  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return irq_oe;
      1: return pwr_oe;
      default: return ks_flag;
    endcase
  endfunction
  // Bounded wait for an output level, then compare
  task automatic wait_eq(input int k, input logic e);
    int i;
    for (i = 0; i < 30 && pick(k) !== e; i++)
      @(posedge clk_sys);
    `CHK(pick(k), e)
    if (pick(k) !== e)
      print_verdict();
  endtask
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input bit wr,
                      input bit sel, output logic [7:0] q);
    bit to;
    mbp_host_model_inst.bus_cycle(a, d, wr, sel, q, to);
    if (to)
    begin
      n_fail++;
      print_verdict();
    end
  endtask
  // Write, then compare latch, pulse count and data with the model
  task automatic wr_chk(input logic [7:0] a, input logic [7:0] d, input bit s);
    int n0;
    logic [7:0] q;
    bit ok;
    n0 = n_wr;
    xfer(a, d, 1'b1, s, q);
    // Supply level read after the strobes, once any change has landed
    ok = s && main_ok;
    repeat (4) @(posedge clk_sys);
    `CHK(last_addr, a)
    `CHK(n_wr - n0, ok ? 1 : 0)
    if (ok)
    begin
      model[a] = d;
      `CHK(wr_seen, d)
    end
  endtask
  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] q;
    xfer(a, 8'h00, 1'b0, 1'b1, q);
    `CHK(q, model[a])
  endtask
  task automatic ks_pulse();
    ks_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    ks_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask
  // Main sequence
  initial
  begin
    logic [7:0] a, f, e;
    void'($urandom(32'hC9331BC5));
    {rst, main_ok, aux_ok, ks_n} = 4'hF;
    {abe, sw_on, wake, ks_clr} = 4'h0;
    flags = 8'h00;
    ens = 8'h00;
    last_bus = 8'h00;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    // Random writes read back
    for (int j = 0; j < 6; j++)
    begin
      a = 8'($urandom);
      wr_chk(a, 8'($urandom), 1'b1);
      rd_chk(a);
    end
    // Back-to-back writes to the top address, deselected, unpowered
    a = 8'hFF;
    wr_chk(a, 8'h5A, 1'b1);
    wr_chk(a, 8'hA5, 1'b1);
    wr_chk(a, 8'h3C, 1'b0);
    rd_chk(a);
    main_ok <= 1'b0;
    wr_chk(a, 8'h11, 1'b1);
    main_ok <= 1'b1;
    rd_chk(a);
    // Interrupt follows enabled flags
    for (int j = 0; j < 8; j++)
    begin
      f = 8'($urandom);
      e = 8'($urandom);
      flags <= f;
      ens <= e;
      @(posedge clk_sys);
      wait_eq(0, |(f & e));
    end
    flags <= 8'h00;
    wait_eq(0, 1'b0);
    `CHK(irq_out, 1'b0)
    // Kickstart as interrupt while supplied
    ks_pulse();
    wait_eq(2, 1'b1);
    wait_eq(0, 1'b1);
    ks_clr <= 1'b1;
    @(posedge clk_sys);
    ks_clr <= 1'b0;
    wait_eq(2, 1'b0);
    wait_eq(0, 1'b0);
    // Power control
    sw_on <= 1'b1;
    wait_eq(1, 1'b1);
    sw_on <= 1'b0;
    wait_eq(1, 1'b0);
    main_ok <= 1'b0;
    ks_pulse();
    repeat (20) @(posedge clk_sys);
    wait_eq(1, 1'b0);
    abe <= 1'b1;
    ks_pulse();
    wait_eq(1, 1'b1);
    `CHK(pwr_out, 1'b0)
    main_ok <= 1'b1;
    wait_eq(1, 1'b0);
    main_ok <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wake <= 1'b1;
    @(posedge clk_sys);
    wake <= 1'b0;
    wait_eq(1, 1'b1);
    main_ok <= 1'b1;
    wait_eq(1, 1'b0);
    print_verdict();
  end
endmodule // muxed_bus_irq_power_pins_tb_top
`default_nettype wire
